// File: ped_apb_slave.sv
`include "ped_defs.svh"

module ped_apb_slave (
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   output ped_pkg::ped_reg_t reg_sel_out,
   output logic setup_rd_out,
   output logic wr_done_out,
   output logic rd_done_out,
   output logic pready_out,
   output logic pslverr_out
);
   import ped_pkg::*;

   logic access;

   always_comb begin
      case (paddr_in)
         `PED_CTRL_OFS: reg_sel_out = PED_REG_CTRL;
         `PED_STS_OFS: reg_sel_out = PED_REG_STS;
         `PED_IST_OFS: reg_sel_out = PED_REG_IST;
         `PED_IMSK_OFS: reg_sel_out = PED_REG_IMSK;
         default: reg_sel_out = PED_REG_NONE;
      endcase
   end

   // no wait states: pready high in every access phase
   assign access = psel_in & penable_in;
   assign pready_out = 1'b1;
   assign pslverr_out = access & (reg_sel_out == PED_REG_NONE);
   assign setup_rd_out = psel_in & ~penable_in & ~pwrite_in;
   // unmapped access completes with an error and changes nothing
   assign wr_done_out = access & pwrite_in & (reg_sel_out != PED_REG_NONE);
   assign rd_done_out = access & ~pwrite_in & (reg_sel_out != PED_REG_NONE);

endmodule : ped_apb_slave

// File: ped_defs.svh
`ifndef PED_DEFS_SVH
`define PED_DEFS_SVH

// register byte offsets
`define PED_CTRL_OFS 12'h450
`define PED_STS_OFS 12'h454
`define PED_IST_OFS 12'h458
`define PED_IMSK_OFS 12'h45C

// field positions
`define PED_POL_BIT 0
`define PED_FIRST_PORT 1

// reset values
`define PED_CTRL_RST 32'h0000_0000
`define PED_STS_RST 32'h0000_0000
`define PED_IST_RST 32'h0000_0000
`define PED_IMSK_RST 32'h0000_0000
`define PED_RDATA_RST 32'h0000_0000

// answer timing: access phase ends in its first cycle
`define PED_WAIT_CYCLES 0

`endif

// File: ped_pkg.sv
package ped_pkg;

   typedef enum logic [2:0] {
      PED_REG_NONE = 3'h0,
      PED_REG_CTRL = 3'h1,
      PED_REG_STS = 3'h3,
      PED_REG_IST = 3'h2,
      PED_REG_IMSK = 3'h6
   } ped_reg_t;

endpackage : ped_pkg

// File: ped_port_gate.sv
module ped_port_gate (
   input wire logic redirect_en_in,
   input wire logic intx_req_in,
   input wire logic msi_req_in,
   input wire logic pme_req_in,
   output logic intx_pass_out,
   output logic msi_pass_out,
   output logic pme_pass_out,
   output logic event_active_out
);
   logic any_req;

   assign any_req = intx_req_in | msi_req_in | pme_req_in;
   // redirected port: native notifications held off
   assign intx_pass_out = intx_req_in & ~redirect_en_in;
   assign msi_pass_out = msi_req_in & ~redirect_en_in;
   assign pme_pass_out = pme_req_in & ~redirect_en_in;
   // event only reported while redirect is on
   assign event_active_out = any_req & redirect_en_in;

endmodule : ped_port_gate

// File: ped_props.sv
module ped_props #(
   parameter int NUM_PORTS = 16
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic hot_rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic pslverr_out,
   input wire logic [NUM_PORTS-1:0] hp_intx_req_in,
   input wire logic [NUM_PORTS-1:0] hp_msi_req_in,
   input wire logic [NUM_PORTS-1:0] hp_pme_req_in,
   input wire logic [NUM_PORTS-1:0] hp_intx_out,
   input wire logic [NUM_PORTS-1:0] hp_msi_out,
   input wire logic [NUM_PORTS-1:0] hp_pme_out,
   input wire logic gpio_alt_sel_in,
   input wire logic shared_event_output_out,
   input wire logic shared_event_output_oe_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic acc;
   logic [NUM_PORTS-1:0] reqs;
   assign acc = psel_in && penable_in;
   assign reqs = hp_intx_req_in | hp_msi_req_in | hp_pme_req_in;
   logic [NUM_PORTS-1:0] ctrl_seen_r;
   logic act;
   // control image rebuilt from bus writes; only the full reset clears it
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         ctrl_seen_r <= '0;
      end else if (acc && pwrite_in && paddr_in == 12'h450) begin
         ctrl_seen_r <= pwdata_in[NUM_PORTS-1:0];
      end
   end
   assign act = |(reqs[NUM_PORTS-1:1] & ctrl_seen_r[NUM_PORTS-1:1]);
   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in || hot_rst_in);
   a_map_error: assert property (
      acc |-> pslverr_out == !(paddr_in inside {12'h450, 12'h454, 12'h458, 12'h45C}))
      else $error("slave error mismatch");
   a_intx_gate: assert property (1 |=> !(hp_intx_out & ~$past(hp_intx_req_in)))
      else $error("intx out without request");
   a_msi_gate: assert property (1 |=> !(hp_msi_out & ~$past(hp_msi_req_in)))
      else $error("msi out without request");
   a_pme_gate: assert property (1 |=> !(hp_pme_out & ~$past(hp_pme_req_in)))
      else $error("pme out without request");
   a_gate_agree: assert property (
      1 |=> !(hp_intx_out & (hp_msi_out ^ $past(hp_msi_req_in))))
      else $error("mechanisms gated apart");
   a_port0_quiet: assert property (!(hp_intx_out[0] | hp_msi_out[0] | hp_pme_out[0]))
      else $error("port 0 notifies");
   // pin moves only on a request change, a register write or a hot reset
   a_pin_cause: assert property ($changed(shared_event_output_out) |->
      $past(acc, 2) && $past(pwrite_in, 2) || $past(reqs) != $past(reqs, 2)
      || $past(hot_rst_in) || $past(hot_rst_in, 2))
      else $error("pin changed without cause");
   a_oe_follows: assert property (
      1 |=> shared_event_output_oe_out == $past(gpio_alt_sel_in))
      else $error("pin enable wrong");
   a_redirect_quiet: assert property (
      1 |=> !((hp_intx_out | hp_msi_out | hp_pme_out) & $past(ctrl_seen_r)))
      else $error("redirected port notifies");
   a_pin_level: assert property (
      1 |=> shared_event_output_out == ($past(act) ~^ $past(ctrl_seen_r[0])))
      else $error("pin level wrong");
endmodule : ped_props

bind port_event_redirect ped_props #(.NUM_PORTS(NUM_PORTS)) u_props (.clk_in, .sys_rst_in,
   .hot_rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pslverr_out,
   .hp_intx_req_in, .hp_msi_req_in, .hp_pme_req_in, .hp_intx_out, .hp_msi_out,
   .hp_pme_out, .gpio_alt_sel_in, .shared_event_output_out, .shared_event_output_oe_out);

// File: ped_sink.sv
module ped_sink (
   input wire logic clk_in,
   input wire logic pin_in,
   input wire logic oe_in,
   output logic level_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic line;
   // undriven pin rests on its pull-up
   assign line = oe_in ? pin_in : 1'b1;
   always_ff @(posedge clk_in) begin
      level_out <= line;
   end
endmodule : ped_sink

// File: port_event_redirect.sv
`include "ped_defs.svh"

// Contract
// - enabled port redirects hot-plug notifications to pin
// - enables read-write, reset zero, survive hot reset
// - pin choice ambiguous; single shared pin used
// - status at 0x454, bit0 zero, bit n port n
// - status bit set while port drives pin
// - status never set without matching enable
// - pin driven only in alternate function; enable lags the select a cycle
// - polarity bit: zero active low, one high
module port_event_redirect #(
   parameter int NUM_PORTS = 16
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic hot_rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic [NUM_PORTS-1:0] hp_intx_req_in,
   input wire logic [NUM_PORTS-1:0] hp_msi_req_in,
   input wire logic [NUM_PORTS-1:0] hp_pme_req_in,
   output logic [NUM_PORTS-1:0] hp_intx_out,
   output logic [NUM_PORTS-1:0] hp_msi_out,
   output logic [NUM_PORTS-1:0] hp_pme_out,
   input wire logic gpio_alt_sel_in,
   output logic shared_event_output_out,
   output logic shared_event_output_oe_out,
   output logic irq_out
);
   import ped_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // reset values at register width

   localparam logic [NUM_PORTS-1:0] CTRL_RST = NUM_PORTS'(`PED_CTRL_RST);
   localparam logic [NUM_PORTS-1:0] STS_RST = NUM_PORTS'(`PED_STS_RST);
   localparam logic [NUM_PORTS-1:0] IST_RST = NUM_PORTS'(`PED_IST_RST);
   localparam logic [NUM_PORTS-1:0] IMSK_RST = NUM_PORTS'(`PED_IMSK_RST);

   ////////////////////////////////////////////////////////////////////////
   // bus decode

   ped_reg_t reg_sel;
   logic setup_rd;
   logic wr_done;
   logic rd_done;

   ped_apb_slave u_apb (
      .psel_in(psel_in),
      .penable_in(penable_in),
      .pwrite_in(pwrite_in),
      .paddr_in(paddr_in),
      .reg_sel_out(reg_sel),
      .setup_rd_out(setup_rd),
      .wr_done_out(wr_done),
      .rd_done_out(rd_done),
      .pready_out(pready_out),
      .pslverr_out(pslverr_out)
   );

   // unmapped offsets never raise a strobe
   logic wr_ctrl;
   logic wr_imsk;
   logic rd_ist;

   assign wr_ctrl = wr_done && (reg_sel == PED_REG_CTRL);
   assign wr_imsk = wr_done && (reg_sel == PED_REG_IMSK);
   assign rd_ist = rd_done && (reg_sel == PED_REG_IST);

   ////////////////////////////////////////////////////////////////////////
   // per-port gating

   logic [NUM_PORTS-1:0] ctrl_r;
   logic [NUM_PORTS-1:0] ctrl_nxt;
   logic [NUM_PORTS-1:0] intx_pass;
   logic [NUM_PORTS-1:0] msi_pass;
   logic [NUM_PORTS-1:0] pme_pass;
   logic [NUM_PORTS-1:0] port_active;

   // bit 0 is the polarity bit, not a port
   assign intx_pass[0] = 1'b0;
   assign msi_pass[0] = 1'b0;
   assign pme_pass[0] = 1'b0;
   assign port_active[0] = 1'b0;

   genvar gi;
   generate
      for (gi = `PED_FIRST_PORT; gi < NUM_PORTS; gi++) begin : g_port
         ped_port_gate u_gate (
            .redirect_en_in(ctrl_r[gi]),
            .intx_req_in(hp_intx_req_in[gi]),
            .msi_req_in(hp_msi_req_in[gi]),
            .pme_req_in(hp_pme_req_in[gi]),
            .intx_pass_out(intx_pass[gi]),
            .msi_pass_out(msi_pass[gi]),
            .pme_pass_out(pme_pass[gi]),
            .event_active_out(port_active[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // control register: sticky, only the full reset clears it

   always_comb begin
      ctrl_nxt = ctrl_r;
      if (wr_ctrl) begin
         ctrl_nxt = pwdata_in[NUM_PORTS-1:0];
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         ctrl_r <= CTRL_RST;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data register; declared early for the interrupt read-clear

   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;

   ////////////////////////////////////////////////////////////////////////
   // live status: follows the ports, bus writes never reach it

   logic [NUM_PORTS-1:0] sts_r;
   logic [NUM_PORTS-1:0] sts_nxt;

   always_comb begin
      // a redirected port counts as signalling while any of its requests stands
      sts_nxt = port_active;
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in || hot_rst_in) begin
         sts_r <= STS_RST;
      end else begin
         sts_r <= sts_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt mask and sticky interrupt status

   logic [NUM_PORTS-1:0] ist_r;
   logic [NUM_PORTS-1:0] ist_nxt;
   logic [NUM_PORTS-1:0] imsk_r;
   logic [NUM_PORTS-1:0] imsk_nxt;
   logic [NUM_PORTS-1:0] ist_taken;
   logic [NUM_PORTS-1:0] ist_rise;
   logic irq_r;
   logic irq_nxt;

   always_comb begin
      imsk_nxt = imsk_r;
      if (wr_imsk) begin
         imsk_nxt = pwdata_in[NUM_PORTS-1:0];
      end
      // bit 0 is the polarity position, no port
      imsk_nxt[0] = 1'b0;
      // clear only what the setup cycle captured: a bit set between
      // setup and access would otherwise be lost unread
      ist_taken = '0;
      if (rd_ist) begin
         ist_taken = rdata_r[NUM_PORTS-1:0];
      end
      // new assertion of a port; set wins over read-clear
      ist_rise = port_active & ~sts_r;
      ist_nxt = (ist_r & ~ist_taken) | ist_rise;
      // irq from the next values, so a mask write acts on its own edge
      irq_nxt = |(ist_nxt & imsk_nxt);
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in || hot_rst_in) begin
         ist_r <= IST_RST;
         imsk_r <= IMSK_RST;
         irq_r <= 1'b0;
      end else begin
         ist_r <= ist_nxt;
         imsk_r <= imsk_nxt;
         irq_r <= irq_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // native notifications, held off for redirected ports

   logic [NUM_PORTS-1:0] intx_r;
   logic [NUM_PORTS-1:0] intx_nxt;
   logic [NUM_PORTS-1:0] msi_r;
   logic [NUM_PORTS-1:0] msi_nxt;
   logic [NUM_PORTS-1:0] pme_r;
   logic [NUM_PORTS-1:0] pme_nxt;

   always_comb begin
      // registered so the native paths and the pin switch on one edge
      intx_nxt = intx_pass;
      msi_nxt = msi_pass;
      pme_nxt = pme_pass;
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in || hot_rst_in) begin
         intx_r <= '0;
         msi_r <= '0;
         pme_r <= '0;
      end else begin
         intx_r <= intx_nxt;
         msi_r <= msi_nxt;
         pme_r <= pme_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // shared event pin level

   logic pin_r;
   logic pin_nxt;
   logic pin_idle;
   logic asserted;

   always_comb begin
      asserted = |port_active;
      // polarity bit: zero drives low when active
      if (ctrl_r[`PED_POL_BIT]) begin
         pin_nxt = asserted;
      end else begin
         pin_nxt = ~asserted;
      end
      // a hot reset keeps the polarity, so the pin rests at its idle level
      pin_idle = ~ctrl_r[`PED_POL_BIT];
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         pin_r <= 1'b1;
      end else if (hot_rst_in) begin
         pin_r <= pin_idle;
      end else begin
         pin_r <= pin_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin output enable

   logic oe_r;
   logic oe_nxt;

   always_comb begin
      // limitation: the enable lags the alternate-function select a cycle
      // one shared pin for all ports; the pin selection sits outside
      oe_nxt = gpio_alt_sel_in;
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in || hot_rst_in) begin
         oe_r <= 1'b0;
      end else begin
         oe_r <= oe_nxt;
      end
   end

   assign hp_intx_out = intx_r;
   assign hp_msi_out = msi_r;
   assign hp_pme_out = pme_r;
   assign shared_event_output_out = pin_r;
   assign shared_event_output_oe_out = oe_r;
   assign irq_out = irq_r;

   ////////////////////////////////////////////////////////////////////////
   // read data, captured in the setup cycle

   always_comb begin
      rdata_nxt = rdata_r;
      if (setup_rd) begin
         case (reg_sel)
            PED_REG_CTRL: rdata_nxt = 32'(ctrl_r);
            PED_REG_STS: rdata_nxt = 32'(sts_r);
            PED_REG_IST: rdata_nxt = 32'(ist_r);
            PED_REG_IMSK: rdata_nxt = 32'(imsk_r);
            default: rdata_nxt = `PED_RDATA_RST;
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         rdata_r <= `PED_RDATA_RST;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign prdata_out = rdata_r;

endmodule : port_event_redirect

// File: tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 1'b0, sys_rst_in = 1'b1, hot_rst_in = 1'b0, gpio_alt_sel_in = 1'b0;
   logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
   logic [11:0] paddr_in = '0;
   logic [31:0] pwdata_in = '0, prdata_out, q;
   logic pready_out, pslverr_out, pin, oe, irq_out, seen, err;
   logic [15:0] ireq = '0, mreq = '0, preq = '0, iout, mout, pout;
   logic [11:0] ofs [4] = '{12'h450, 12'h454, 12'h458, 12'h45C};
   int bad_count = 0, comparisons = 0;
   always #20 clk_in = ~clk_in;
   port_event_redirect u_dut (.clk_in, .sys_rst_in, .hot_rst_in, .psel_in, .penable_in,
      .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
      .hp_intx_req_in(ireq), .hp_msi_req_in(mreq), .hp_pme_req_in(preq),
      .hp_intx_out(iout), .hp_msi_out(mout), .hp_pme_out(pout), .gpio_alt_sel_in,
      .shared_event_output_out(pin), .shared_event_output_oe_out(oe), .irq_out);
   ped_sink u_sink (.clk_in, .pin_in(pin), .oe_in(oe), .level_out(seen));
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask : tick
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_in);
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      @(posedge clk_in);
      while (pready_out !== 1'b1) @(posedge clk_in);
      q = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask : apb
   ////////////////////////////////////////////////////////////////////////////////
   task t_regs;
      foreach (ofs[i]) begin
         apb(1'b0, ofs[i], '0);
         chk(q, 32'h0);
         chk(err, 1'b0);
      end
      apb(1'b0, 12'h460, '0);
      chk(err, 1'b1);
      apb(1'b1, 12'h450, 32'hFFFF_FFFF);
      apb(1'b0, 12'h450, '0);
      chk(q, 32'h0000_FFFF);
      apb(1'b1, 12'h454, 32'hFFFF_FFFF);
      apb(1'b0, 12'h454, '0);
      chk(q, 32'h0);
      $display("t_regs done");
   endtask : t_regs
   task t_redirect;
      apb(1'b1, 12'h450, 32'h0000_8040);
      apb(1'b1, 12'h45C, 32'h0);
      // port 3 left disabled, port 6 redirected
      ireq <= 16'h0048;
      mreq <= 16'h0048;
      tick(2);
      chk(iout, 16'h0008);
      chk(mout, 16'h0008);
      chk(pin, 1'b0);
      chk(irq_out, 1'b0);
      apb(1'b0, 12'h454, '0);
      chk(q, 32'h40);
      apb(1'b1, 12'h45C, 32'h40);
      tick(2);
      chk(irq_out, 1'b1);
      apb(1'b0, 12'h458, '0);
      chk(q, 32'h40);
      tick(2);
      chk(irq_out, 1'b0);
      ireq <= '0;
      mreq <= '0;
      tick(2);
      chk(pin, 1'b1);
      apb(1'b0, 12'h454, '0);
      chk(q, 32'h0);
      $display("t_redirect done");
   endtask : t_redirect
   task t_polar;
      apb(1'b1, 12'h450, 32'h0000_8001);
      preq <= 16'h8004;
      tick(2);
      chk(pout, 16'h0004);
      chk(pin, 1'b1);
      preq <= '0;
      tick(2);
      chk(pin, 1'b0);
      hot_rst_in <= 1'b1;
      tick(2);
      hot_rst_in <= 1'b0;
      apb(1'b0, 12'h450, '0);
      chk(q, 32'h8001);
      sys_rst_in <= 1'b1;
      tick(2);
      sys_rst_in <= 1'b0;
      apb(1'b0, 12'h450, '0);
      chk(q, 32'h0);
      $display("t_polar done");
   endtask : t_polar
   task t_alt;
      gpio_alt_sel_in <= 1'b1;
      apb(1'b1, 12'h450, 32'h4);
      preq <= 16'h0004;
      tick(3);
      chk(oe, 1'b1);
      chk(seen, 1'b0);
      gpio_alt_sel_in <= 1'b0;
      tick(3);
      chk(oe, 1'b0);
      chk(seen, 1'b1);
      chk(pin, 1'b0);
      $display("t_alt done");
   endtask : t_alt
   ////////////////////////////////////////////////////////////////////////////////
   task end_of_test;
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_of_test
   initial begin
      tick(4);
      sys_rst_in <= 1'b0;
      t_regs;
      t_redirect;
      t_polar;
      t_alt;
      end_of_test;
   end
   // tests need about 85 cycles; allow about thirty times that
   initial begin
      #100000;
      bad_count++;
      end_of_test;
   end
endmodule : tb
